// *** logic/row_scan_char_generator_regs.svh ***
// Purpose: shared constants of the row scanning character generator
// Assumes: included by its bare name from every design file but the package
// Notes: definitions only, no logic
`ifndef ROW_SCAN_CHAR_GENERATOR_REGS_SVH
`define ROW_SCAN_CHAR_GENERATOR_REGS_SVH

// character code and glyph geometry
`define CODE_W      6
`define GLYPH_COUNT 64
`define DOT_W       5
`define ROW_W       3
`define GLYPH_ROWS  7
`define GLYPH_BITS  35

// index of the bottom glyph row
`define LAST_ROW    3'h6

// all dots high: background, nothing lit
`define BLANK_ROW   5'h1F

// default font: plain alternating dots, replace with real artwork
`define DEFAULT_FONT {1120{2'h2}}

`endif

// *** logic/row_scan_char_generator_pkg.sv ***
// Purpose: types of the row scanning character generator
// Assumes: used as row_scan_char_generator_pkg::name, never imported
// Notes: the counter has nine states: lead blank, seven rows, trail blank
`default_nettype none

package row_scan_char_generator_pkg;

	// coarse phase of the row counter; the row index refines the glyph phase
	typedef enum logic [1:0] {
		ST_LEAD_BLANK,
		ST_GLYPH,
		ST_TRAIL_BLANK
	} rowState_t;

endpackage

`default_nettype wire

// *** logic/glyph_store.sv ***
// Purpose: font store, one five dot row per code and row index
// Assumes: row index stays below seven
// Notes: read data registered, one ref_clk behind the address
`timescale 1ns/100ps
`default_nettype none
`include "row_scan_char_generator_regs.svh"

module glyph_store #(
	parameter logic [`GLYPH_COUNT*`GLYPH_BITS-1:0] FONT = `DEFAULT_FONT
) (
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	input  wire logic [`CODE_W-1:0] code,
	input  wire logic [`ROW_W-1:0]  row,
	output logic      [`DOT_W-1:0]  rowData
);

	// bit offset of a row: glyphs of 35 bits, top row lowest
	function automatic logic [11:0] bitBase(
		input logic [`CODE_W-1:0] c,
		input logic [`ROW_W-1:0]  r
	);
		bitBase = 12'(c) * 12'(`GLYPH_BITS) + 12'(r) * 12'(`DOT_W);
	endfunction

	wire logic [11:0] rowBase = bitBase(code, row);

	// registered read, blank until the first fetch
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rowData <= `BLANK_ROW;
		end else begin
			rowData <= FONT[rowBase +: `DOT_W];
		end
	end

endmodule

`default_nettype wire

// *** logic/row_scan_char_generator.sv ***
// Purpose: 64 character 5x7 dot matrix generator, one row per row clock
// Assumes: row clock and master reset pins synchronous to ref_clk
// Notes: row clock is sampled; the counter steps on its falling edge
// Operation
// - master reset low puts the nine state row counter in its first state
// - six bit character code selects one of 64 stored glyphs
// - first row clock after master reset release shows the top row
// - each further row clock shows the next of the six remaining rows
// - first and last counter states drive all dots high, blank
// - counter holds in its last state, blanked, until next master reset
// - counter and dots change after the row clock goes low
// - master reset low forces dots high regardless of the row clock
// - lit dots are stored as 0, background as 1
// - code bit zero weighs 1, bit five weighs 32
// - each glyph is seven five dot rows, top first, dot five is msb
`timescale 1ns/100ps
`default_nettype none
`include "row_scan_char_generator_regs.svh"

module row_scan_char_generator #(
	parameter logic [`GLYPH_COUNT*`GLYPH_BITS-1:0] FONT = `DEFAULT_FONT
) (
	input  wire logic               ref_clk,
	input  wire logic               resetn,
	input  wire logic               dotClk,
	input  wire logic               masterResetN,
	input  wire logic [`CODE_W-1:0] charCode,
	output logic      [`DOT_W-1:0]  dotOut
);

	// code bits: index 0 is the 1 weight, index 5 the 32 weight
	wire logic charCodeLsb = charCode[0];
	wire logic charCodeMsb = charCode[`CODE_W-1];

	row_scan_char_generator_pkg::rowState_t state_reg;
	row_scan_char_generator_pkg::rowState_t state_next;
	logic [`ROW_W-1:0] rowIdx_reg;
	logic [`ROW_W-1:0] rowIdx_next;
	logic              dotClkPrev_reg;
	logic [`DOT_W-1:0] rowData;

	// one cycle pulse on a high to low row clock
	wire logic rowStep = dotClkPrev_reg & ~dotClk;
	wire logic inGlyph =
		(state_reg == row_scan_char_generator_pkg::ST_GLYPH);
	wire logic atLastRow = (rowIdx_reg == `LAST_ROW);

	// row clock history for edge detection
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			dotClkPrev_reg <= 1'b0;
		end else begin
			dotClkPrev_reg <= dotClk;
		end
	end

	// counter advance: master reset first, then falling row clock
	always_comb begin
		state_next  = state_reg;
		rowIdx_next = rowIdx_reg;
		if (!masterResetN) begin
			state_next  = row_scan_char_generator_pkg::ST_LEAD_BLANK;
			rowIdx_next = '0;
		end else if (rowStep) begin
			unique case (state_reg)
				row_scan_char_generator_pkg::ST_LEAD_BLANK: begin
					state_next  = row_scan_char_generator_pkg::ST_GLYPH;
					rowIdx_next = '0;
				end
				row_scan_char_generator_pkg::ST_GLYPH: begin
					if (atLastRow) begin
						state_next = row_scan_char_generator_pkg::ST_TRAIL_BLANK;
					end else begin
						rowIdx_next = rowIdx_reg + 3'h1;
					end
				end
				row_scan_char_generator_pkg::ST_TRAIL_BLANK: begin
					state_next = state_reg;
				end
				default: begin
					state_next = row_scan_char_generator_pkg::ST_TRAIL_BLANK;
				end
			endcase
		end
	end

	// counter register; power up dead ended until a master reset
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg  <= row_scan_char_generator_pkg::ST_TRAIL_BLANK;
			rowIdx_reg <= '0;
		end else begin
			state_reg  <= state_next;
			rowIdx_reg <= rowIdx_next;
		end
	end

	// store addressed by the next row, so data lines up with the state
	glyph_store #(
		.FONT    (FONT)
	) u_glyph_store (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.code    (charCode),
		.row     (rowIdx_next),
		.rowData (rowData)
	);

	// blanking: master reset and the two blank states force ones
	wire logic forceBlank = !masterResetN || !inGlyph;
	assign dotOut = forceBlank ? `BLANK_ROW : rowData;

	// helper: code and row seen one cycle earlier
	logic [`CODE_W-1:0] codePrev_reg;
	logic [`ROW_W-1:0]  rowPrev_reg;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			codePrev_reg <= '0;
			rowPrev_reg  <= '0;
		end else begin
			codePrev_reg <= charCode;
			rowPrev_reg  <= rowIdx_next;
		end
	end

	// expected dots of the code seen one cycle earlier and the current row, read straight from FONT
	wire logic [11:0] expBase =
		12'(codePrev_reg) * 12'(`GLYPH_BITS) + 12'(rowPrev_reg) * 12'(`DOT_W);
	wire logic [`DOT_W-1:0] expRow = FONT[expBase +: `DOT_W];

	// master reset sends the counter to the lead blank state
	a_reset_first: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		!masterResetN |=>
			state_reg == row_scan_char_generator_pkg::ST_LEAD_BLANK
	) else $error("master reset did not reach lead blank state");

	// dots follow the stored row of the addressed glyph
	a_glyph_select: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		masterResetN && inGlyph |-> dotOut == expRow
	) else $error("dots differ from addressed glyph row");

	// first falling clock after release shows the top row
	a_top_row: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		masterResetN && rowStep &&
		state_reg == row_scan_char_generator_pkg::ST_LEAD_BLANK
		##1 masterResetN |->
			inGlyph && rowIdx_reg == 3'h0 && dotOut == expRow
	) else $error("top row not shown after release");

	// every step above the bottom row moves one row down
	a_row_advance: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		masterResetN && rowStep && inGlyph && !atLastRow |=>
			inGlyph && rowIdx_reg == $past(rowIdx_reg) + 3'h1
	) else $error("row did not advance by one");

	// outside the glyph rows the dots read blank
	a_blank_states: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		!inGlyph |-> dotOut == `BLANK_ROW
	) else $error("dots not blank in a blank state");

	// bottom row step leads to the trail state, which then holds
	a_dead_end: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		masterResetN && rowStep && inGlyph && atLastRow |=>
			(state_reg == row_scan_char_generator_pkg::ST_TRAIL_BLANK
			&& masterResetN)[*3] or !masterResetN
	) else $error("counter left the last state without reset");

	// trail state never moves without master reset
	a_trail_hold: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		masterResetN &&
		state_reg == row_scan_char_generator_pkg::ST_TRAIL_BLANK |=>
			state_reg == row_scan_char_generator_pkg::ST_TRAIL_BLANK
	) else $error("trail state left without master reset");

	// nothing steps without a falling row clock
	a_fall_only: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		masterResetN && !rowStep |=>
			$stable(state_reg) && $stable(rowIdx_reg)
	) else $error("counter moved without a falling row clock");

	// master reset low blanks the dots at once
	a_reset_blank: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		$fell(masterResetN) |-> dotOut == `BLANK_ROW
	) else $error("dots not blank under master reset");

	// code change within a row shows the new glyph one cycle later
	a_code_follow: assert property (
		@(posedge ref_clk) disable iff (!resetn)
		masterResetN && inGlyph && !rowStep && $changed(charCode)
		##1 masterResetN && inGlyph |->
			dotOut == expRow && !$changed(rowIdx_reg)
	) else $error("dots did not follow a code change");

endmodule

`default_nettype wire

// *** test/row_load_model.sv ***
// Purpose: display serialiser parallel load stage at the dot outputs
// Assumes: loads while the row clock stands high, before it falls
// Notes: holds the row last handed to the shift chain
`timescale 1ns/100ps
`default_nettype none
`include "row_scan_char_generator_regs.svh"

module row_load_model (
	input  wire logic              ref_clk,
	input  wire logic              dotClk,
	input  wire logic [`DOT_W-1:0] dotOut,
	output logic      [`DOT_W-1:0] heldRow
);
	// parallel load of the row shown before the falling row clock
	always_ff @(posedge ref_clk) begin
		if (dotClk) begin
			heldRow <= dotOut;
		end
	end
endmodule

`default_nettype wire

// *** test/row_scan_char_generator_tb_top.sv ***
// Purpose: self checking bench of the row scanning character generator
// Assumes: inputs driven on the falling ref_clk edge
// Notes: a coined font gives every tested code its own rows
`timescale 1ns/100ps
`default_nettype none
`include "row_scan_char_generator_regs.svh"

module row_scan_char_generator_tb_top;
	// coined font row: distinct per tested code and row
	function automatic logic [4:0] glyphRow(int c, int r);
		return 5'(c + (c >> 5) * 13 + r * 11);
	endfunction
	function automatic logic [2239:0] makeFont();
		logic [2239:0] f;
		f = '0;
		for (int c = 0; c < 64; c++) begin
			for (int r = 0; r < 7; r++) begin
				f[c*35+r*5 +: 5] = glyphRow(c, r);
			end
		end
		return f;
	endfunction
	localparam logic [2239:0] FONT = makeFont();
	logic              ref_clk      = 1'b0;
	logic              resetn       = 1'b0;
	logic              dotClk       = 1'b0;
	logic              masterResetN = 1'b1;
	logic [`CODE_W-1:0] charCode    = 6'h00;
	logic [`DOT_W-1:0] dotOut;
	logic [`DOT_W-1:0] heldRow;
	int                badCount     = 0;
	int                checks       = 0;
	int                cycles       = 0;
	// codes walked: all zeros, each single bit, all ones
	logic [5:0] codeTab [8] = '{6'h00, 6'h01, 6'h02, 6'h04,
		6'h08, 6'h10, 6'h20, 6'h3F};

	always #12.5 ref_clk = ~ref_clk;

	row_scan_char_generator #(.FONT(FONT)) dut (
		.ref_clk      (ref_clk),
		.resetn       (resetn),
		.dotClk       (dotClk),
		.masterResetN (masterResetN),
		.charCode     (charCode),
		.dotOut       (dotOut)
	);
	row_load_model model (
		.ref_clk (ref_clk),
		.dotClk  (dotClk),
		.dotOut  (dotOut),
		.heldRow (heldRow)
	);

	task automatic check(input logic [4:0] exp, input string what);
		checks++;
		if (dotOut !== exp) begin
			badCount++;
			$display("Error %s expected %h seen %h", what, exp, dotOut);
		end
	endtask
	// one high then low level on the row clock, settled afterwards
	task automatic fall();
		@(negedge ref_clk) dotClk = 1'b1;
		@(negedge ref_clk) dotClk = 1'b0;
		@(negedge ref_clk);
	endtask
	// master reset pulse, released ahead of the next falling row clock
	task automatic mreset();
		@(negedge ref_clk) masterResetN = 1'b0;
		#1 check(5'h1F, "reset blank");
		@(negedge ref_clk) masterResetN = 1'b1;
		@(negedge ref_clk);
	endtask
	task automatic finalReport();
		$display("checks %0d mismatches %0d", checks, badCount);
		if (badCount == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			badCount++;
			finalReport();
		end
	end

	initial begin
		repeat (6) @(negedge ref_clk);
		resetn = 1'b1;
		fall();
		check(5'h1F, "power-up blank");
		// table walk: nine states per code
		foreach (codeTab[i]) begin
			charCode = codeTab[i];
			mreset();
			check(5'h1F, "lead blank");
			for (int r = 0; r < 7; r++) begin
				fall();
				check(glyphRow(codeTab[i], r), "glyph row");
			end
			fall();
			check(5'h1F, "trail blank");
			checks++;
			if (heldRow !== glyphRow(codeTab[i], 6)) begin
				badCount++;
				$display("Error held row expected %h seen %h",
					glyphRow(codeTab[i], 6), heldRow);
			end
			fall();
			check(5'h1F, "dead end");
		end
		// rising row clock alone does not step
		charCode = 6'h01;
		mreset();
		@(negedge ref_clk) dotClk = 1'b1;
		@(negedge ref_clk);
		check(5'h1F, "no step on rise");
		dotClk = 1'b0;
		@(negedge ref_clk);
		check(glyphRow(1, 0), "step on fall");
		// code change inside a glyph row, no row clock
		charCode = 6'h20;
		@(negedge ref_clk);
		check(glyphRow(32, 0), "code change");
		fall();
		check(glyphRow(32, 1), "next row");
		finalReport();
	end
endmodule

`default_nettype wire
